/* File: core/scir_regs.sv */
// Strap capture and per-device serial number readback register group
// Notes on behaviour
// - Straps are captured when reset releases and held until next reset.
// - Soft readback bit 7 holds captured strap select; 1 is hard mode.
// - Soft mode: bits 6:4 encode GPIO3/GPIO2 three-level pair as codes 0 to 5.
// - In hard mode the soft three-level field reads zero.
// - Hard mode: hard readback bits 7:2 equal captured GPIO5:0 pattern.
// - In soft mode the hard six-bit field reads zero.
// - A read-only byte returns serial number bits 15:8 from non-volatile memory.
// - A read-only byte returns serial number bits 7:0 from non-volatile memory.
// - Serial bytes are always loaded from non-volatile memory, never user writable.
`timescale 1ns/1ps

module scir_regs
#(
    // Serial number bits held here; two readback bytes carry all of them
    parameter int SERIAL_W = 16,
    // Binary strap pins captured in hard mode
    parameter int HARD_W = 6,
    // Width of the soft-mode three-level code
    parameter int SOFT_W = 3
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Strap pins
    input wire scir_pkg::scir_straps_t straps,
    // Non-volatile memory load of serial number
    input wire logic nvm_load_valid,
    input wire logic [15:0] nvm_serial,
    // Serial register port
    input wire scir_pkg::scir_req_t req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Captured strap select for the rest of the device
    output logic strap_select_captured
);
    import scir_pkg::*;

    // Timing of this group, for whoever wires it in:
    // an edge that sees nrst low arms the capture and clears every register;
    // the first edge that sees nrst high takes the strap pins, and only that one;
    // a read taken at that same edge still answers with the reset values,
    // so a host should wait one more cycle before reading the readback bytes;
    // every read taken on an edge is answered at the next edge, for one cycle;
    // the serial number reads zero until the memory has handed it over;
    // writes are accepted on the port but decoded nowhere, so they change nothing;
    // pins may move freely after capture without disturbing what reads back.

    // Refused sizes: ports and byte map are fixed, so other widths cannot be served
    // Serial number must fill exactly two readback bytes
    if (SERIAL_W != 16)
    begin : g_bad_serial_w
        $error("scir_regs: SERIAL_W must be 16");
    end
    // Hard field must fill bits 7:2 of its readback byte
    if (HARD_W != 6)
    begin : g_bad_hard_w
        $error("scir_regs: HARD_W must be 6");
    end
    // Soft code must fill bits 6:4 of its readback byte
    if (SOFT_W != 3)
    begin : g_bad_soft_w
        $error("scir_regs: SOFT_W must be 3");
    end

    // Capture sequencer states: armed by reset, held after the single capture
    typedef enum logic [0:0]
    {
        SCIR_CAP_ARMED = 1'b0,
        SCIR_CAP_HELD = 1'b1
    } scir_cap_state_t;

    // Three-level pair to code; a floating GPIO3 counts as low, a free choice
    function automatic logic [2:0] soft_code(input scir_level_t g3, input scir_level_t g2);
        logic [2:0] base;
        logic [2:0] code;
        base = (g3 == SCIR_LVL_HIGH) ? SCIR_CODE_HL : SCIR_CODE_LL;
        case (g2)
            SCIR_LVL_LOW: code = base;
            SCIR_LVL_FLOAT: code = base + 3'h1;
            SCIR_LVL_HIGH: code = base + 3'h2;
            default: code = base;
        endcase
        return code;
    endfunction : soft_code

    // Address decode for the host port; unmapped offsets read as zero
    function automatic logic [7:0] read_lookup(
        input logic [7:0] addr,
        input logic [7:0] sn_hi,
        input logic [7:0] sn_lo,
        input logic [7:0] soft_rb,
        input logic [7:0] hard_rb
    );
        logic [7:0] data;
        case (addr)
            SCIR_OFS_SN_BY1: data = sn_hi;
            SCIR_OFS_SN_BY0: data = sn_lo;
            SCIR_OFS_SOFT_RB: data = soft_rb;
            SCIR_OFS_HARD_RB: data = hard_rb;
            default: data = 8'h00;
        endcase
        return data;
    endfunction : read_lookup

    // Strap pins by name
    logic pin_select;
    scir_level_t pin_gpio3;
    scir_level_t pin_gpio2;
    logic [5:0] pin_binary;
    assign pin_select = straps.strap_select_pin;
    assign pin_gpio3 = straps.gpio3_level;
    assign pin_gpio2 = straps.gpio2_level;
    assign pin_binary = straps.gpio_binary;

    // Capture state
    scir_cap_state_t cap_state_r;
    scir_cap_state_t cap_state_nxt;
    logic sel_r;
    logic sel_nxt;
    logic [SOFT_W-1:0] soft_strap_code_r;
    logic [SOFT_W-1:0] soft_strap_code_nxt;
    logic [HARD_W-1:0] hard_strap_pattern_r;
    logic [HARD_W-1:0] hard_strap_pattern_nxt;

    // Pin levels already gated by the strap select, ready to be captured
    logic [SOFT_W-1:0] soft_gated;
    logic [HARD_W-1:0] hard_gated;

    // Next value of the outward select copy
    logic strap_select_captured_nxt;

    // Serial number state
    logic [SERIAL_W-1:0] serial_r;
    logic [SERIAL_W-1:0] serial_nxt;
    logic [7:0] serial_byte [SERIAL_W/8];

    // Read path
    logic [7:0] soft_rb_byte;
    logic [7:0] hard_rb_byte;
    logic [7:0] rd_data_nxt;
    logic rd_valid_nxt;

    // Soft code is forced to zero in hard mode so a stale pair cannot leak out
    assign soft_gated = pin_select ? SCIR_CODE_LL :
        soft_code(pin_gpio3, pin_gpio2);

    // One gate per binary strap pin; soft mode forces the whole field to zero
    for (genvar b = 0; b < HARD_W; b++)
    begin : g_hard_bit
        assign hard_gated[b] = pin_select & pin_binary[b];
    end

    // Next capture state: take the gated pins once, on the first edge out of reset
    always_comb
    begin
        cap_state_nxt = cap_state_r;
        sel_nxt = sel_r;
        soft_strap_code_nxt = soft_strap_code_r;
        hard_strap_pattern_nxt = hard_strap_pattern_r;
        case (cap_state_r)
            SCIR_CAP_ARMED:
            begin
                sel_nxt = pin_select;
                soft_strap_code_nxt = soft_gated;
                hard_strap_pattern_nxt = hard_gated;
                cap_state_nxt = SCIR_CAP_HELD;
            end
            SCIR_CAP_HELD:
            begin
                // Pins may move freely now; nothing follows them until the next reset
                cap_state_nxt = SCIR_CAP_HELD;
            end
            default:
            begin
                cap_state_nxt = SCIR_CAP_HELD;
            end
        endcase
    end

    // Capture registers; the reset branch loads constants only
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            cap_state_r <= SCIR_CAP_ARMED;
            sel_r <= SCIR_RB_RST[SCIR_SEL_BIT];
            soft_strap_code_r <= SCIR_RB_RST[SCIR_SOFT_LSB +: SOFT_W];
            hard_strap_pattern_r <= SCIR_RB_RST[SCIR_HARD_LSB +: HARD_W];
        end
        else
        begin
            cap_state_r <= cap_state_nxt;
            sel_r <= sel_nxt;
            soft_strap_code_r <= soft_strap_code_nxt;
            hard_strap_pattern_r <= hard_strap_pattern_nxt;
        end
    end

    // Outward copy of the captured select; its own flop keeps the port glitch free
    always_comb
    begin
        strap_select_captured_nxt = strap_select_captured;
        if (cap_state_r == SCIR_CAP_ARMED)
        begin
            strap_select_captured_nxt = pin_select;
        end
    end

    // Outward select register
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            strap_select_captured <= SCIR_RB_RST[SCIR_SEL_BIT];
        end
        else
        begin
            strap_select_captured <= strap_select_captured_nxt;
        end
    end

    // Serial number only ever comes from the memory load; the host has no path in
    always_comb
    begin
        serial_nxt = serial_r;
        if (nvm_load_valid)
        begin
            serial_nxt = nvm_serial;
        end
    end

    // Serial register; reads before the load see zero, which users must allow for
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            serial_r <= SCIR_SN_RST;
        end
        else
        begin
            serial_r <= serial_nxt;
        end
    end

    // Serial number split into readback bytes, byte 1 the most significant
    for (genvar k = 0; k < SERIAL_W / 8; k++)
    begin : g_serial_byte
        assign serial_byte[k] = serial_r[8 * k +: 8];
    end

    // Readback bytes with reserved positions tied to zero
    assign soft_rb_byte = {sel_r, soft_strap_code_r, 4'h0};
    assign hard_rb_byte = {hard_strap_pattern_r, 2'h0};

    // Read data; writes are never decoded, so wr_en and wdata reach no register
    always_comb
    begin
        rd_data_nxt = 8'h00;
        if (req.rd_en)
        begin
            rd_data_nxt = read_lookup(req.addr, serial_byte[1], serial_byte[0], soft_rb_byte,
                hard_rb_byte);
        end
    end

    // Read data register; zero whenever no read was taken
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            rd_data <= 8'h00;
        end
        else
        begin
            rd_data <= rd_data_nxt;
        end
    end

    // Answer strobe; every read is answered, mapped or not, one cycle later
    always_comb
    begin
        rd_valid_nxt = 1'b0;
        if (req.rd_en)
        begin
            rd_valid_nxt = 1'b1;
        end
    end

    // Answer strobe register; it stands for exactly one cycle per read
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_valid_nxt;
        end
    end

endmodule : scir_regs

/* File: core/scir_pkg.sv */
// Package for the strap capture and serial number readback registers
package scir_pkg;

    // Register offsets (byte-wide registers on the serial register port)
    localparam logic [7:0] SCIR_OFS_SN_BY1 = 8'h06;
    localparam logic [7:0] SCIR_OFS_SN_BY0 = 8'h07;
    localparam logic [7:0] SCIR_OFS_SOFT_RB = 8'h08;
    localparam logic [7:0] SCIR_OFS_HARD_RB = 8'h09;

    // Field positions
    localparam int SCIR_SEL_BIT = 7;
    localparam int SCIR_SOFT_LSB = 4;
    localparam int SCIR_HARD_LSB = 2;

    // Reset values
    localparam logic [7:0] SCIR_RB_RST = 8'h00;
    localparam logic [15:0] SCIR_SN_RST = 16'h0000;

    // Three-level pin states as sampled by the pad detector
    typedef enum logic [1:0]
    {
        SCIR_LVL_LOW = 2'b00,
        SCIR_LVL_FLOAT = 2'b01,
        SCIR_LVL_HIGH = 2'b10
    } scir_level_t;

    // Soft-mode code values
    localparam logic [2:0] SCIR_CODE_LL = 3'h0;
    localparam logic [2:0] SCIR_CODE_LF = 3'h1;
    localparam logic [2:0] SCIR_CODE_LH = 3'h2;
    localparam logic [2:0] SCIR_CODE_HL = 3'h3;
    localparam logic [2:0] SCIR_CODE_HF = 3'h4;
    localparam logic [2:0] SCIR_CODE_HH = 3'h5;

    // Strap pins as presented by the pads
    typedef struct packed
    {
        logic strap_select_pin;
        scir_level_t gpio3_level;
        scir_level_t gpio2_level;
        logic [5:0] gpio_binary;
    } scir_straps_t;

    // Register read and write request
    typedef struct packed
    {
        logic rd_en;
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scir_req_t;

endpackage : scir_pkg

/* File: tb/scir_properties.sv */
// Checker for the strap capture register group
`timescale 1ns/1ps
module scir_properties
(
    // Watched ports
    input wire logic ref_clk,
    input wire logic nrst,
    input wire scir_pkg::scir_straps_t straps,
    input wire logic nvm_load_valid,
    input wire logic [15:0] nvm_serial,
    input wire scir_pkg::scir_req_t req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic strap_select_captured
);
    import scir_pkg::*;
    logic [15:0] sn_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Last serial handed over by the memory
    always_ff @(posedge ref_clk)
    begin
        sn_r <= !nrst ? 16'h0000 : nvm_load_valid ? nvm_serial : sn_r;
    end
    property p_ans; 1'b1 |=> rd_valid == $past(req.rd_en); endproperty
    a_ans: assert property (p_ans) else $error("bad answer pulse");
    property p_cap; !$past(nrst)
        |=> strap_select_captured == $past(straps.strap_select_pin); endproperty
    a_cap: assert property (p_cap) else $error("bad capture");
    property p_hold; $past(nrst) |=> $stable(strap_select_captured); endproperty
    a_hold: assert property (p_hold) else $error("capture moved");
    property p_sel; req.rd_en && req.addr == SCIR_OFS_SOFT_RB
        |=> rd_data[7] == $past(strap_select_captured) && rd_data[3:0] == 4'h0; endproperty
    a_sel: assert property (p_sel) else $error("bad select bit");
    property p_soft; req.rd_en && req.addr == SCIR_OFS_SOFT_RB && strap_select_captured
        |=> rd_data[6:0] == 7'h00; endproperty
    a_soft: assert property (p_soft) else $error("soft field set");
    property p_hard; req.rd_en && req.addr == SCIR_OFS_HARD_RB && !strap_select_captured
        |=> rd_data == 8'h00; endproperty
    a_hard: assert property (p_hard) else $error("hard field set");
    property p_sn1; req.rd_en && req.addr == SCIR_OFS_SN_BY1 |=> rd_data == $past(sn_r[15:8]);
    endproperty
    a_sn1: assert property (p_sn1) else $error("bad serial high");
    property p_sn0; req.rd_en && req.addr == SCIR_OFS_SN_BY0 |=> rd_data == $past(sn_r[7:0]);
    endproperty
    a_sn0: assert property (p_sn0) else $error("bad serial low");
    property p_code; req.rd_en && req.addr == SCIR_OFS_SOFT_RB && !strap_select_captured
        |=> rd_data[6:4] <= SCIR_CODE_HH; endproperty
    a_code: assert property (p_code) else $error("soft code out of range");
    property p_pat; req.rd_en && req.addr == SCIR_OFS_HARD_RB && strap_select_captured
        |=> rd_data[1:0] == 2'h0; endproperty
    a_pat: assert property (p_pat) else $error("hard reserved bits set");
endmodule : scir_properties
bind scir_regs scir_properties chk (.ref_clk, .nrst, .straps, .nvm_load_valid, .nvm_serial,
    .req, .rd_data, .rd_valid, .strap_select_captured);

/* File: tb/scir_board.sv */
// Board straps and serial memory model
`timescale 1ns/1ps
module scir_board
#(
    parameter logic [15:0] SN = 16'h0000
)
(
    // Clock, reset and chosen pins
    input wire logic ref_clk,
    input wire logic nrst,
    input wire scir_pkg::scir_straps_t pins,
    // Pads and memory load
    output scir_pkg::scir_straps_t straps,
    output logic nvm_load_valid,
    output logic [15:0] nvm_serial
);
    logic up_r;
    // Memory hands the serial over once after reset; bus shows junk otherwise
    always_ff @(posedge ref_clk) up_r <= nrst;
    assign nvm_load_valid = nrst && !up_r;
    assign nvm_serial = nvm_load_valid ? SN : ~SN;
    assign straps = pins;
endmodule : scir_board

/* File: tb/scir_regs_tb.sv */
// Self-checking bench for the strap capture register group
`timescale 1ns/1ps
module scir_regs_tb;
    import scir_pkg::*;
    localparam logic [15:0] SN = 16'hA5C3;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    scir_straps_t pins = '0;
    scir_straps_t straps;
    scir_req_t req = '0;
    logic nvm_load_valid;
    logic [15:0] nvm_serial;
    logic [7:0] rd_data;
    logic rd_valid;
    logic strap_select_captured;
    int n_fail = 0;
    int comparisons = 0;
    always #4 ref_clk = ~ref_clk;
    scir_board #(.SN(SN)) board (.ref_clk, .nrst, .pins, .straps, .nvm_load_valid, .nvm_serial);
    scir_regs DUT (.ref_clk, .nrst, .straps, .nvm_load_valid, .nvm_serial, .req, .rd_data,
        .rd_valid, .strap_select_captured);
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Answer stands only in the cycle after the read is taken
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk) #1 req = '{1'b1, 1'b0, a, 8'h00};
        @(posedge ref_clk) #1 req.rd_en = 1'b0;
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, exp);
    endtask : rd
    task print_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    // Six soft codes, then two hard patterns; pins move after capture
    initial
    begin
        for (int i = 0; i < 8; i++)
        begin
            pins = '{i > 5, (i % 6) > 2 ? SCIR_LVL_HIGH : SCIR_LVL_LOW,
                scir_level_t'(2'(i % 3)), i > 6 ? 6'h3F : 6'h15};
            nrst = 1'b0;
            repeat (12) @(posedge ref_clk);
            #1 nrst = 1'b1;
            repeat (2) @(posedge ref_clk);
            #1 chk(8'(strap_select_captured), 8'(i > 5));
            pins = '{~pins.strap_select_pin, SCIR_LVL_HIGH, SCIR_LVL_HIGH, ~pins.gpio_binary};
            @(posedge ref_clk) #1 req = '{1'b0, 1'b1, 8'(6 + i % 4), 8'h5A};
            rd(SCIR_OFS_SOFT_RB, i > 5 ? 8'h80 : {1'b0, 3'(i), 4'h0});
            rd(SCIR_OFS_HARD_RB, i == 6 ? 8'h54 : i == 7 ? 8'hFC : 8'h00);
            rd(SCIR_OFS_SN_BY1, SN[15:8]);
            rd(SCIR_OFS_SN_BY0, SN[7:0]);
            rd(8'h0A, 8'h00);
        end
        print_verdict();
    end
endmodule : scir_regs_tb
